// ---- include/eu_pkg.sv ----
// Shared constants and types of the enhanced serial port
package eu_pkg;
  localparam int unsigned EU_AW        = 8;
  localparam int unsigned EU_DW        = 32;
  localparam logic [7:0]  EU_ADDR_DATA  = 8'h00;
  localparam logic [7:0]  EU_ADDR_CTRL  = 8'h04;
  localparam logic [7:0]  EU_ADDR_STAT  = 8'h08;
  localparam logic [7:0]  EU_ADDR_MASK  = 8'h0c;
  localparam logic [7:0]  EU_ADDR_BAUD  = 8'h10;
  localparam logic [7:0]  EU_ADDR_MATCH = 8'h14;
  localparam int unsigned EU_BCW        = 17;
  localparam int unsigned EU_BITS       = 8;
  localparam logic [3:0]  EU_SYNC_DIV   = 4'hc;
  localparam logic [3:0]  EU_SYNC_HALF  = 4'h6;
  localparam logic [16:0] EU_FIX_FAST   = 17'h00020;
  localparam logic [16:0] EU_FIX_SLOW   = 17'h00040;
  localparam logic [15:0] EU_BAUD_RST   = 16'h06c8;
  localparam logic [3:0]  EU_NBITS8     = 4'h8;
  localparam logic [3:0]  EU_NBITS9     = 4'h9;

  typedef enum logic [1:0] {EU_SYNC, EU_ASYNC8, EU_ASYNC9_FIX, EU_ASYNC9_VAR} eu_mode_t;

  typedef struct packed {
    eu_mode_t mode;
    logic     mpe;
    logic     ren;
    logic     tb9;
    logic     rb9;
    logic     tx_done;
    logic     rx_done;
  } eu_ctrl_t;

  typedef struct packed {
    logic ferr;
    logic ovr;
    logic tx_done;
    logic rx_done;
  } eu_stat_t;

  typedef struct packed {
    logic        smod;
    logic [15:0] div;
  } eu_baud_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] addr;
  } eu_match_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       nine;
  } eu_txreq_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } eu_rxres_t;
endpackage

// ---- rtl/eu_tx.sv ----
// Asynchronous character transmitter
`timescale 1ns/1ps
module eu_tx import eu_pkg::*; #(
  parameter int unsigned BCW = EU_BCW
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           start,
  input  eu_txreq_t           req,
  input  wire logic [BCW-1:0] bit_cyc,
  output logic                txd,
  output logic                busy,
  output logic                done
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} eu_txst_t;
  typedef struct packed {
    eu_txst_t       st;
    logic [BCW-1:0] cnt;
    logic [3:0]     bitn;
    logic [8:0]     sh;
    logic           txd;
    logic           done;
  } eu_txs_t;

  eu_txs_t r;
  eu_txs_t n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    unique case (r.st)
      TX_IDLE: begin
        n.txd = 1'b1;
        if (start) begin
          n.st   = TX_START;
          n.sh   = {req.ninth, req.data};
          n.bitn = req.nine ? EU_NBITS9 : EU_NBITS8;
          n.cnt  = bit_cyc - 1'b1;
          n.txd  = 1'b0;
        end
      end
      TX_START, TX_BITS: begin
        n.cnt = r.cnt - 1'b1;
        if (r.cnt == '0) begin
          n.cnt = bit_cyc - 1'b1;
          if (r.bitn == '0) begin
            n.st   = TX_STOP;
            n.txd  = 1'b1;
            n.done = 1'b1;
          end else begin
            n.st   = TX_BITS;
            n.txd  = r.sh[0];
            n.sh   = {1'b0, r.sh[8:1]};
            n.bitn = r.bitn - 1'b1;
          end
        end
      end
      TX_STOP: begin
        n.cnt = r.cnt - 1'b1;
        if (r.cnt == '0) begin
          n.st = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: TX_IDLE, cnt: '0, bitn: '0, sh: '0, txd: 1'b1, done: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign txd  = r.txd;
  assign busy = (r.st != TX_IDLE);
  assign done = r.done;

  property p_tx_start;
    @(posedge pclk) disable iff (!presetn) (start && !busy) |=> !txd && busy;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not sent");

  property p_tx_stop;
    @(posedge pclk) disable iff (!presetn) done |-> txd ##1 txd;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("stop bit not high");
endmodule

// ---- rtl/eu_rx.sv ----
// Asynchronous character receiver
`timescale 1ns/1ps
module eu_rx import eu_pkg::*; #(
  parameter int unsigned BCW = EU_BCW
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           rxd,
  input  wire logic           enable,
  input  wire logic           nine,
  input  wire logic [BCW-1:0] bit_cyc,
  output logic                done,
  output eu_rxres_t           res
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} eu_rxst_t;
  typedef struct packed {
    eu_rxst_t       st;
    logic [BCW-1:0] cnt;
    logic [3:0]     bitn;
    logic [8:0]     sh;
    logic           prev;
    logic           done;
    eu_rxres_t      res;
  } eu_rxs_t;

  eu_rxs_t r;
  eu_rxs_t n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.prev = rxd;
    unique case (r.st)
      RX_IDLE: begin
        if (enable && r.prev && !rxd) begin
          n.st  = RX_START;
          n.cnt = bit_cyc >> 1;
        end
      end
      RX_START: begin
        n.cnt = r.cnt - 1'b1;
        if (r.cnt == '0) begin
          n.st   = rxd ? RX_IDLE : RX_BITS;
          n.cnt  = bit_cyc - 1'b1;
          n.bitn = nine ? EU_NBITS9 : EU_NBITS8;
        end
      end
      RX_BITS: begin
        n.cnt = r.cnt - 1'b1;
        if (r.cnt == '0) begin
          n.cnt  = bit_cyc - 1'b1;
          n.sh   = {rxd, r.sh[8:1]};
          n.bitn = r.bitn - 1'b1;
          if (r.bitn == 4'h1) begin
            n.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        n.cnt = r.cnt - 1'b1;
        if (r.cnt == '0) begin
          n.st        = RX_IDLE;
          n.done      = 1'b1;
          n.res.stop  = rxd;
          n.res.ninth = r.sh[8];
          n.res.data  = nine ? r.sh[7:0] : r.sh[8:1];
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: RX_IDLE, cnt: '0, bitn: '0, sh: '0, prev: 1'b1, done: 1'b0, res: '0};
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
  assign res  = r.res;

  property p_rx_false_start;
    @(posedge pclk) disable iff (!presetn)
      (r.st == RX_START && r.cnt == '0 && rxd) |=> (r.st == RX_IDLE);
  endproperty
  a_rx_false_start: assert property (p_rx_false_start) else $error("false start kept");
endmodule

// ---- rtl/eu_core.sv ----
// Enhanced serial port with APB registers, sync shifter and interrupt
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Async full duplex or sync half duplex
// - Completed byte moves to holding register
// - Overrun set when byte arrives unread
// - One data address: write transmits, read receives
// - Transmit-done flag bit 1, set on completion
// - Receive-done flag bit 0, set on completion
// - Flags cleared only by software
// - Flags raise interrupt and can be polled
// - Frame error detect and address recognition
// - Sync mode: eight bits LSB first, clock/12
// - Eight-bit async: start, eight data, stop
// - Nine-bit async: start, eight, ninth, stop
// - Async8 loads only if flag clear, and stop ok when mpe set
module eu_core import eu_pkg::*; (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [EU_AW-1:0] paddr,
  input  wire logic [EU_DW-1:0] pwdata,
  output logic      [EU_DW-1:0] prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             rxd_in,
  output logic                  rxd_out,
  output logic                  rxd_oe,
  output logic                  txd,
  output logic                  irq
);
  typedef enum logic [1:0] {S_IDLE, S_TX, S_RX} eu_sst_t;
  typedef struct packed {
    eu_mode_t         mode;
    logic             mpe;
    logic             ren;
    logic             tb9;
    logic             rb9;
    eu_stat_t         stat;
    eu_stat_t         mask;
    eu_baud_t         baud;
    eu_match_t        match;
    logic [7:0]       rx_buf;
    eu_txreq_t        txreq;
    logic             tx_start;
    eu_sst_t          sst;
    logic [3:0]       sdiv;
    logic [3:0]       sbit;
    logic [7:0]       ssh;
    logic [EU_DW-1:0] prdata;
    logic             pready;
    logic             pslverr;
    logic             txd;
    logic             rxd_out;
    logic             rxd_oe;
    logic             irq;
  } eu_core_t;

  eu_core_t        r;
  eu_core_t        n;
  logic            tx_line;
  logic            tx_busy;
  logic            tx_done_p;
  logic            rx_done_p;
  eu_rxres_t       rx_res;
  logic [EU_BCW-1:0] bit_cyc;
  logic            async_md;
  logic            addr_ok;
  logic            accept;
  logic            wr_hit;
  logic            rx_clr;
  eu_ctrl_t        ctrl_view;
  eu_ctrl_t        ctrl_w;

  assign async_md = (r.mode != EU_SYNC);
  assign bit_cyc  = (r.mode == EU_ASYNC9_FIX) ? (r.baud.smod ? EU_FIX_FAST : EU_FIX_SLOW)
                                               : {1'b0, r.baud.div};
  assign addr_ok  = (((rx_res.data ^ r.match.addr) & r.match.mask) == 8'h00);
  assign accept   = (r.mode == EU_ASYNC8) ? (!r.mpe || rx_res.stop)
                                          : (!r.mpe || (rx_res.ninth && addr_ok));
  assign wr_hit   = psel && penable && r.pready && pwrite;
  assign rx_clr   = wr_hit && ((paddr == EU_ADDR_CTRL && ctrl_w.rx_done) ||
                               (paddr == EU_ADDR_STAT && pwdata[0]));
  assign ctrl_w   = eu_ctrl_t'(pwdata[$bits(eu_ctrl_t)-1:0]);
  assign ctrl_view = '{mode: r.mode, mpe: r.mpe, ren: r.ren, tb9: r.tb9, rb9: r.rb9,
                       tx_done: r.stat.tx_done, rx_done: r.stat.rx_done};

  eu_tx #(
    .BCW (EU_BCW)
  ) u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (r.tx_start),
    .req     (r.txreq),
    .bit_cyc (bit_cyc),
    .txd     (tx_line),
    .busy    (tx_busy),
    .done    (tx_done_p)
  );

  eu_rx #(
    .BCW (EU_BCW)
  ) u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd     (rxd_in),
    .enable  (r.ren && async_md),
    .nine    (r.mode != EU_ASYNC8),
    .bit_cyc (bit_cyc),
    .done    (rx_done_p),
    .res     (rx_res)
  );

  always_comb begin
    n = r;
    n.tx_start = 1'b0;
    n.pready   = psel && penable && !r.pready;
    n.pslverr  = 1'b0;
    n.rxd_out  = 1'b0;
    // Register read, answered one cycle into the access phase
    if (psel && penable && !r.pready) begin
      unique case (paddr)
        EU_ADDR_DATA:  n.prdata = EU_DW'(r.rx_buf);
        EU_ADDR_CTRL:  n.prdata = EU_DW'(ctrl_view);
        EU_ADDR_STAT:  n.prdata = EU_DW'(r.stat);
        EU_ADDR_MASK:  n.prdata = EU_DW'(r.mask);
        EU_ADDR_BAUD:  n.prdata = EU_DW'(r.baud);
        EU_ADDR_MATCH: n.prdata = EU_DW'(r.match);
        default: begin
          n.prdata  = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    // Register writes; clears first so that events below win
    if (wr_hit) begin
      unique case (paddr)
        EU_ADDR_DATA: begin
          n.txreq = '{data: pwdata[7:0], ninth: r.tb9, nine: (r.mode != EU_ASYNC8)};
          if (async_md && !tx_busy && !r.tx_start) begin
            n.tx_start = 1'b1;
          end else if (!async_md && r.sst == S_IDLE) begin
            n.sst  = S_TX;
            n.ssh  = pwdata[7:0];
            n.sdiv = '0;
            n.sbit = '0;
          end
        end
        EU_ADDR_CTRL: begin
          n.mode = ctrl_w.mode;
          n.mpe  = ctrl_w.mpe;
          n.ren  = ctrl_w.ren;
          n.tb9  = ctrl_w.tb9;
          n.stat.rx_done = r.stat.rx_done && !ctrl_w.rx_done;
          n.stat.tx_done = r.stat.tx_done && !ctrl_w.tx_done;
        end
        EU_ADDR_STAT:  n.stat  = r.stat & ~eu_stat_t'(pwdata[$bits(eu_stat_t)-1:0]);
        EU_ADDR_MASK:  n.mask  = eu_stat_t'(pwdata[$bits(eu_stat_t)-1:0]);
        EU_ADDR_BAUD:  n.baud  = eu_baud_t'(pwdata[$bits(eu_baud_t)-1:0]);
        EU_ADDR_MATCH: n.match = eu_match_t'(pwdata[$bits(eu_match_t)-1:0]);
        default: ;
      endcase
    end
    // Synchronous half-duplex shifter
    unique case (r.sst)
      S_IDLE: begin
        n.rxd_oe = 1'b0;
        if (!async_md && n.sst == S_IDLE && r.ren && !r.stat.rx_done) begin
          n.sst  = S_RX;
          n.sdiv = '0;
          n.sbit = '0;
        end
      end
      S_TX, S_RX: begin
        n.sdiv   = r.sdiv + 1'b1;
        n.rxd_oe = (r.sst == S_TX) && !r.ssh[0];
        if (r.sst == S_RX && r.sdiv == EU_SYNC_HALF - 1'b1) begin
          n.ssh = {rxd_in, r.ssh[7:1]};
        end
        if (r.sdiv == EU_SYNC_DIV - 1'b1) begin
          n.sdiv = '0;
          n.sbit = r.sbit + 1'b1;
          if (r.sst == S_TX) begin
            n.ssh = {1'b0, r.ssh[7:1]};
          end
          if (r.sbit == 4'(EU_BITS - 1)) begin
            n.sst = S_IDLE;
            if (r.sst == S_TX) begin
              n.stat.tx_done = 1'b1;
            end else begin
              n.rx_buf       = r.ssh;
              n.stat.rx_done = 1'b1;
            end
          end
        end
      end
      default: n.sst = S_IDLE;
    endcase
    // Asynchronous completions
    if (tx_done_p) begin
      n.stat.tx_done = 1'b1;
    end
    if (rx_done_p) begin
      if (!rx_res.stop) begin
        n.stat.ferr = 1'b1;
      end
      if (r.stat.rx_done) begin
        n.stat.ovr = 1'b1;
      end else if (accept) begin
        n.rx_buf       = rx_res.data;
        n.rb9          = (r.mode == EU_ASYNC8) ? rx_res.stop : rx_res.ninth;
        n.stat.rx_done = 1'b1;
      end
    end
    n.txd = async_md ? tx_line : ((r.sst == S_IDLE) || (r.sdiv >= EU_SYNC_HALF));
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{mode: EU_SYNC, baud: '{smod: 1'b0, div: EU_BAUD_RST}, sst: S_IDLE,
             txd: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign rxd_out = r.rxd_out;
  assign rxd_oe  = r.rxd_oe;
  assign txd     = r.txd;
  assign irq     = r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_read_data;
    psel && penable && r.pready && !pwrite && paddr == EU_ADDR_DATA;
  endsequence

  property p_data_read;
    s_apb_read_data |-> prdata[7:0] == $past(r.rx_buf) && prdata[31:8] == '0;
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong");

  property p_rx_set;
    (rx_done_p && !r.stat.rx_done && accept) |=> r.stat.rx_done && r.rx_buf == $past(rx_res.data);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive flag not set");

  property p_tx_set;
    tx_done_p |=> r.stat.tx_done;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("transmit flag not set");

  property p_rx_hold;
    (r.stat.rx_done && !rx_clr) |=> r.stat.rx_done;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("flag cleared by hardware");

  property p_ovr_set;
    (rx_done_p && r.stat.rx_done) |=> r.stat.ovr && $stable(r.rx_buf);
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");

  property p_ovr_hold;
    (r.stat.ovr && !(wr_hit && paddr == EU_ADDR_STAT)) |=> r.stat.ovr;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");

  property p_mpe_block;
    (rx_done_p && r.mode == EU_ASYNC8 && r.mpe && !rx_res.stop && !r.stat.rx_done
     && !(wr_hit && paddr == EU_ADDR_DATA)) |=> !r.stat.rx_done && $stable(r.rx_buf);
  endproperty
  a_mpe_block: assert property (p_mpe_block) else $error("bad stop accepted");

  property p_ferr;
    (rx_done_p && !rx_res.stop) |=> r.stat.ferr;
  endproperty
  a_ferr: assert property (p_ferr) else $error("frame error missed");

  property p_irq;
    |(r.stat & r.mask) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_sclk_high;
    (r.mode == EU_SYNC && r.sst != S_IDLE && $rose(txd)) |=> txd [*5];
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("shift clock high short");

  property p_sclk_low;
    (r.mode == EU_SYNC && $fell(txd)) |=> !txd [*5];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("shift clock low short");
endmodule

// ---- testbench/eu_peer.sv ----
// Serial peer model on the transmit and receive lines
`timescale 1ns/1ps
module eu_peer #(
  parameter int PER = 16
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      drv
);
  initial drv = 1'b1;

  task automatic put(input logic v);
    drv <= v;
    repeat (PER) @(posedge pclk);
  endtask

  // Start, data LSB first, optional ninth, stop, then idle
  task automatic send(input logic [7:0] b, input logic has9, input logic n9,
                      input logic stp);
    int i;
    put(1'b0);
    for (i = 0; i < 8; i++)
      put(b[i]);
    if (has9)
      put(n9);
    put(stp);
    put(1'b1);
  endtask

  // Samples each bit in its middle
  task automatic recv(input int p, output logic [7:0] b, output logic stp);
    int i;
    @(negedge txd);
    repeat (p/2) @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      repeat (p) @(posedge pclk);
      b[i] = txd;
    end
    repeat (p) @(posedge pclk);
    stp = txd;
  endtask

  // Sync slave: next bit after each shift clock rise
  task automatic shift_out(input logic [7:0] b);
    int i;
    drv <= b[0];
    for (i = 1; i < 8; i++) begin
      @(posedge txd);
      drv <= b[i];
    end
    @(posedge txd);
    drv <= 1'b1;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Testbench for the enhanced serial port
`timescale 1ns/1ps
module tb;
  import eu_pkg::*;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [EU_AW-1:0] paddr;
  logic [EU_DW-1:0] pwdata;
  logic [EU_DW-1:0] prdata;
  logic             pready;
  logic             pslverr;
  logic             rxd_out;
  logic             rxd_oe;
  logic             txd;
  logic             irq;
  logic             drv;
  logic             line;
  logic [EU_DW-1:0] q;
  logic             err;
  logic [7:0]       rb;
  logic             rs;
  logic [7:0]       sb;
  logic             mon;
  logic             txd_q;
  int               rises;
  int               gap;
  int               last = 0;
  int               cyc = 0;
  int               miscompares;
  int               comparisons;

  // Open-drain line with pull-up
  assign line = (rxd_oe ? rxd_out : 1'b1) & drv;

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  eu_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .irq(irq)
  );

  eu_peer #(.PER(16)) u_peer (.pclk(pclk), .txd(txd), .drv(drv));

  // Sync shift monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    txd_q <= txd;
    if (!mon) begin
      rises <= 0;
    end else if (txd && !txd_q) begin
      sb <= {line, sb[7:1]};
      rises <= rises + 1;
    end else if (!txd && txd_q) begin
      gap <= cyc - last;
      last <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic waits(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, EU_ADDR_STAT, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 400);
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up;
  end

  initial begin
    {psel, penable, pwrite, mon} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, EU_ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, EU_ADDR_BAUD, 32'h0);
    chk(q, {16'h0, EU_BAUD_RST});
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1'b1, EU_ADDR_BAUD, 32'h10);
    apb(1'b1, EU_ADDR_CTRL, 32'h50);
    fork
      apb(1'b1, EU_ADDR_DATA, 32'ha5);
      u_peer.recv(16, rb, rs);
    join
    chk({24'h0, rb}, 32'ha5);
    chk({31'h0, rs}, 32'h1);
    apb(1'b0, EU_ADDR_CTRL, 32'h0);
    chk(q, 32'h52);
    apb(1'b1, EU_ADDR_STAT, 32'h2);
    apb(1'b0, EU_ADDR_CTRL, 32'h0);
    chk(q, 32'h50);
    $display("test async transmit done");
    u_peer.send(8'h3c, 1'b0, 1'b0, 1'b1);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, EU_ADDR_DATA, 32'h0);
    chk(q, 32'h3c);
    apb(1'b0, EU_ADDR_CTRL, 32'h0);
    chk(q, 32'h55);
    u_peer.send(8'hc3, 1'b0, 1'b0, 1'b1);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, EU_ADDR_DATA, 32'h0);
    chk(q, 32'h3c);
    apb(1'b1, EU_ADDR_CTRL, 32'h51);
    u_peer.send(8'h69, 1'b0, 1'b0, 1'b1);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, EU_ADDR_DATA, 32'h0);
    chk(q, 32'h69);
    apb(1'b1, EU_ADDR_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, EU_ADDR_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, EU_ADDR_STAT, 32'h4);
    $display("test receive and overrun done");
    apb(1'b1, EU_ADDR_CTRL, 32'h70);
    u_peer.send(8'h77, 1'b0, 1'b0, 1'b0);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h8);
    apb(1'b1, EU_ADDR_STAT, 32'h8);
    apb(1'b1, EU_ADDR_MATCH, 32'hff5a);
    apb(1'b1, EU_ADDR_CTRL, 32'hf0);
    u_peer.send(8'h5a, 1'b1, 1'b0, 1'b1);
    apb(1'b0, EU_ADDR_STAT, 32'h0);
    chk(q, 32'h0);
    u_peer.send(8'h5a, 1'b1, 1'b1, 1'b1);
    apb(1'b0, EU_ADDR_DATA, 32'h0);
    chk(q, 32'h5a);
    apb(1'b0, EU_ADDR_CTRL, 32'h0);
    chk(q, 32'hf5);
    apb(1'b1, EU_ADDR_STAT, 32'h1);
    $display("test frame and address done");
    apb(1'b1, EU_ADDR_CTRL, 32'h00);
    mon <= 1'b1;
    apb(1'b1, EU_ADDR_DATA, 32'h96);
    waits(1);
    chk(q, 32'h2);
    chk({24'h0, sb}, 32'h96);
    chk(32'(rises), 32'h8);
    chk(32'(gap), 32'hc);
    mon <= 1'b0;
    $display("test sync transmit done");
    fork
      apb(1'b1, EU_ADDR_CTRL, 32'h10);
      u_peer.shift_out(8'h4b);
    join
    waits(0);
    chk(q, 32'h3);
    apb(1'b1, EU_ADDR_CTRL, 32'h01);
    apb(1'b0, EU_ADDR_DATA, 32'h0);
    chk(q, 32'h4b);
    $display("test sync receive done");
    apb(1'b1, EU_ADDR_BAUD, 32'h10000);
    apb(1'b1, EU_ADDR_CTRL, 32'h88);
    fork
      apb(1'b1, EU_ADDR_DATA, 32'h3a);
      u_peer.recv(32, rb, rs);
    join
    chk({24'h0, rb}, 32'h3a);
    chk({31'h0, rs}, 32'h1);
    $display("test fixed rate transmit done");
    wrap_up;
  end
endmodule
